// *** inc/rail_monitor_params.svh ***
// register offsets, field positions, reset values and encodings of the rail monitor bank
// assumes 8-bit register addresses on the device-internal register port
`ifndef RAIL_MONITOR_PARAMS_SVH
`define RAIL_MONITOR_PARAMS_SVH
`define ADDR_COMP_H_CONFIG 8'hE4
`define ADDR_FAULT_MASK_A 8'hE5
`define ADDR_FAULT_MASK_B 8'hE6
`define ADDR_GOOD_STATUS_A 8'hE7
`define ADDR_GOOD_STATUS_B 8'hE8
`define ADDR_MISC_CONTROL 8'hE9
`define RST_COMP_H_CONFIG 8'h00
`define RST_FAULT_MASK 8'h00
`define RST_GOOD_STATUS 8'h00
`define RST_MISC_CONTROL 8'h10
`define POS_DISCHARGE 7
`define POS_SHIFT_HI 6
`define POS_SHIFT_LO 3
`define POS_NOMINAL_HI 2
`define POS_NOMINAL_LO 0
`define MASK_B_RESERVED 8'hFC
`define STATUS_B_RESERVED 8'hE0
`define SHIFT_CODE_LAST_PERCENT 4'h7
`define SHIFT_CODE_LAST_ABSOLUTE 4'h9
`define NOMINAL_CODE_1V0 3'h0
`endif

// *** inc/rail_monitor_pkg.sv ***
// types shared by the rail monitor register bank
// assumes the constants header is included alongside
package rail_monitor_pkg;
    typedef enum logic [2:0] {
        NOM_1V0 = 3'h0, NOM_1V2 = 3'h1, NOM_1V5 = 3'h2, NOM_1V8 = 3'h3,
        NOM_1V1 = 3'h4, NOM_1V35 = 3'h5, NOM_3V3 = 3'h6, NOM_2V5_5V0 = 3'h7
    } nominal_voltage_code_e;

    typedef struct packed {
        logic window_h_discharge_enable;
        logic [3:0] window_h_shift_code;
        nominal_voltage_code_e window_h_nominal_code;
    } window_h_config_s;

    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // 13 rails in two status bytes: a = 13,10,9,8,7,6,5,4; b = 12,11,11s,8s,6s
    typedef struct packed {
        logic [7:0] group_a;
        logic [4:0] group_b;
    } rail_flags_s;
endpackage

// *** design/window_h_decode.sv ***
// decodes the window H configuration into a threshold selection
// assumes the analogue side consumes the binary threshold index selection below
`timescale 1ns/1ps
`include "rail_monitor_params.svh"
module window_h_decode
    import rail_monitor_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input rail_monitor_pkg::window_h_config_s config_i,
    // decoded selection
    output logic absolute_mode_o,
    output logic [3:0] threshold_index_o,
    output logic shift_code_valid_o
);
    // 1 V nominal selects absolute thresholds, any other nominal a percentage
    wire logic is_absolute = (config_i.window_h_nominal_code == NOM_1V0);
    wire logic [3:0] code = config_i.window_h_shift_code;
    wire logic valid_next = is_absolute ? (code <= `SHIFT_CODE_LAST_ABSOLUTE)
                                        : (code <= `SHIFT_CODE_LAST_PERCENT);

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            absolute_mode_o <= 1'b1;
            threshold_index_o <= 4'h0;
            shift_code_valid_o <= 1'b1;
        end else begin
            absolute_mode_o <= is_absolute;
            threshold_index_o <= code;
            shift_code_valid_o <= valid_next;
        end
    end

    chk_absolute_follows: assert property (@(posedge clk_i) disable iff (reset_i)
        1'b1 |=> absolute_mode_o == ($past(config_i.window_h_nominal_code) == NOM_1V0))
        else $error("absolute mode does not follow nominal code");
    chk_percent_range: assert property (@(posedge clk_i) disable iff (reset_i)
        (config_i.window_h_nominal_code != NOM_1V0 && config_i.window_h_shift_code == 4'h8)
        |=> !shift_code_valid_o)
        else $error("percent shift code 8 accepted");
endmodule

// *** design/rail_monitor_fault_mask_regs.sv ***
// register bank for window comparator H, rail fault masks and rail pass status
// assumes a device-internal register port, one access per cycle, from the serial interface
`timescale 1ns/1ps
`include "rail_monitor_params.svh"
// Overview of operation
// - bit 7 of window H config enables 100 ohm discharge; resets to 0.
// - above 1.05 V nominal, shift codes 0 to 7 give +3% down to -4%.
// - at 1 V nominal, shift codes select absolute thresholds, codes 8 and 9 too.
// - bits 2 to 0 encode the nominal window voltage.
// - first mask byte: one read-write ignore bit per rail 4..10 and 13.
// - second mask byte: rail 11 in bit 1, rail 12 in bit 0, reset 0.
// - reserved bits of second mask and second status bytes read as ones.
// - first status byte read-only, pass flags of rails 13 and 10..4, resets zero.
// - second status byte bit 4 rail 12, bit 3 rail 11, read-only.
// - second status bits 2..0 report switched rails 11s, 8s and 6s.
// - registers sit at E4 through E9; window H config resets to zero.
module rail_monitor_fault_mask_regs
    import rail_monitor_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // register port
    input rail_monitor_pkg::reg_req_s req_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    // monitor results
    input rail_monitor_pkg::rail_flags_s rail_pass_i,
    input rail_monitor_pkg::rail_flags_s rail_fault_i,
    // window H controls
    output rail_monitor_pkg::window_h_config_s window_h_config_o,
    output logic window_h_absolute_mode_o,
    output logic [3:0] window_h_threshold_index_o,
    output logic window_h_shift_code_valid_o,
    // gated faults and misc byte
    output rail_monitor_pkg::rail_flags_s rail_fault_active_o,
    output logic [7:0] miscellaneous_control_o
);
    logic [7:0] comparator_h_config_reg;
    logic [7:0] rail_fault_mask_a_reg;
    logic [1:0] rail_fault_mask_b_reg;
    logic [7:0] rail_good_status_a_reg;
    logic [4:0] rail_good_status_b_reg;
    logic [7:0] miscellaneous_control_reg;
    logic [7:0] rdata_reg;
    logic rvalid_reg;
    logic [12:0] fault_active_reg;

    // every check in this module runs on the bank clock and is void while reset stands
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        hit = (a == target);
    endfunction

    wire logic wr_config = req_i.write && hit(req_i.addr, `ADDR_COMP_H_CONFIG);
    wire logic wr_mask_a = req_i.write && hit(req_i.addr, `ADDR_FAULT_MASK_A);
    wire logic wr_mask_b = req_i.write && hit(req_i.addr, `ADDR_FAULT_MASK_B);
    wire logic wr_misc = req_i.write && hit(req_i.addr, `ADDR_MISC_CONTROL);

    // mask byte a bit order: 7..0 = rails 4,5,6,7,8,9,10,13; status a order: 13,10..4
    wire logic [7:0] mask_a_in_status_order = {rail_fault_mask_a_reg[0],
        rail_fault_mask_a_reg[1], rail_fault_mask_a_reg[2], rail_fault_mask_a_reg[3],
        rail_fault_mask_a_reg[4], rail_fault_mask_a_reg[5], rail_fault_mask_a_reg[6],
        rail_fault_mask_a_reg[7]};
    // group b = {12, 11, 11s, 8s, 6s}; switched rails have no mask bit of their own
    wire logic [4:0] mask_b_in_status_order = {rail_fault_mask_b_reg[0],
        rail_fault_mask_b_reg[1], 3'h0};
    wire logic [12:0] fault_active_next = {rail_fault_i.group_a & ~mask_a_in_status_order,
        rail_fault_i.group_b & ~mask_b_in_status_order};

    wire logic [7:0] status_b_view =
        `STATUS_B_RESERVED | {3'h0, rail_good_status_b_reg};
    wire logic [7:0] mask_b_view = `MASK_B_RESERVED | {6'h00, rail_fault_mask_b_reg};
    wire logic [7:0] rdata_next =
        hit(req_i.addr, `ADDR_COMP_H_CONFIG) ? comparator_h_config_reg :
        hit(req_i.addr, `ADDR_FAULT_MASK_A) ? rail_fault_mask_a_reg :
        hit(req_i.addr, `ADDR_FAULT_MASK_B) ? mask_b_view :
        hit(req_i.addr, `ADDR_GOOD_STATUS_A) ? rail_good_status_a_reg :
        hit(req_i.addr, `ADDR_GOOD_STATUS_B) ? status_b_view :
        hit(req_i.addr, `ADDR_MISC_CONTROL) ? miscellaneous_control_reg : 8'h00;

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            comparator_h_config_reg <= `RST_COMP_H_CONFIG;
            rail_fault_mask_a_reg <= `RST_FAULT_MASK;
            rail_fault_mask_b_reg <= 2'h0;
            miscellaneous_control_reg <= `RST_MISC_CONTROL;
        end else begin
            if (wr_config) comparator_h_config_reg <= req_i.wdata;
            if (wr_mask_a) rail_fault_mask_a_reg <= req_i.wdata;
            if (wr_mask_b) rail_fault_mask_b_reg <= req_i.wdata[1:0];
            if (wr_misc) miscellaneous_control_reg <= req_i.wdata;
        end
    end

    // status has no write path at all; it tracks the monitors one cycle late
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rail_good_status_a_reg <= `RST_GOOD_STATUS;
            rail_good_status_b_reg <= 5'h00;
        end else begin
            rail_good_status_a_reg <= rail_pass_i.group_a;
            rail_good_status_b_reg <= rail_pass_i.group_b;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
            fault_active_reg <= 13'h0000;
        end else begin
            rdata_reg <= req_i.read ? rdata_next : 8'h00;
            rvalid_reg <= req_i.read;
            fault_active_reg <= fault_active_next;
        end
    end

    assign rdata_o = rdata_reg;
    assign rvalid_o = rvalid_reg;
    assign rail_fault_active_o = fault_active_reg;
    assign miscellaneous_control_o = miscellaneous_control_reg;
    assign window_h_config_o = comparator_h_config_reg;

    window_h_decode u_decode (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .config_i(window_h_config_o),
        .absolute_mode_o(window_h_absolute_mode_o),
        .threshold_index_o(window_h_threshold_index_o),
        .shift_code_valid_o(window_h_shift_code_valid_o)
    );

    // a read is taken on one edge and its answer stands for the whole next cycle
    sequence s_read_config;
        req_i.read && req_i.addr == `ADDR_COMP_H_CONFIG;
    endsequence
    sequence s_read_mask_a;
        req_i.read && req_i.addr == `ADDR_FAULT_MASK_A;
    endsequence
    sequence s_read_mask_b;
        req_i.read && req_i.addr == `ADDR_FAULT_MASK_B;
    endsequence
    sequence s_read_status_a;
        req_i.read && req_i.addr == `ADDR_GOOD_STATUS_A;
    endsequence
    sequence s_read_status_b;
        req_i.read && req_i.addr == `ADDR_GOOD_STATUS_B;
    endsequence
    sequence s_read_unmapped;
        req_i.read && (req_i.addr < `ADDR_COMP_H_CONFIG || req_i.addr > `ADDR_MISC_CONTROL);
    endsequence
    // a config write lands on the next edge and reaches the decoder one edge later
    sequence s_write_config;
        req_i.write && req_i.addr == `ADDR_COMP_H_CONFIG;
    endsequence

    chk_config_read: assert property (s_read_config |=>
        rvalid_o && rdata_o == $past(comparator_h_config_reg))
        else $error("config read wrong");
    chk_mask_a_read: assert property (s_read_mask_a |=>
        rvalid_o && rdata_o == $past(rail_fault_mask_a_reg))
        else $error("mask a read wrong");
    chk_mask_b_reserved: assert property (s_read_mask_b |=>
        rvalid_o && rdata_o[7:2] == 6'h3F)
        else $error("mask b reserved bits not ones");
    chk_status_b_reserved: assert property (s_read_status_b |=>
        rvalid_o && rdata_o[7:5] == 3'h7 && rdata_o[4:0] == $past(rail_good_status_b_reg))
        else $error("status b read wrong");
    chk_status_read: assert property (s_read_status_a |=>
        rvalid_o && rdata_o == $past(rail_good_status_a_reg))
        else $error("status a read wrong");
    chk_unmapped_read: assert property (s_read_unmapped |=>
        rvalid_o && rdata_o == 8'h00)
        else $error("unmapped read not zero");

    // status has no write path, so any write must leave it tracking the monitors
    chk_status_a_live: assert property (1'b1 |=>
        rail_good_status_a_reg == $past(rail_pass_i.group_a))
        else $error("status a not following monitors");
    chk_status_b_live: assert property (1'b1 |=>
        rail_good_status_b_reg == $past(rail_pass_i.group_b))
        else $error("status b not following monitors");
    chk_status_no_write: assert property (
        (req_i.write && req_i.addr == `ADDR_GOOD_STATUS_B) |=>
        rail_good_status_b_reg == $past(rail_pass_i.group_b))
        else $error("status b disturbed by write");

    chk_mask_a_store: assert property (
        (req_i.write && req_i.addr == `ADDR_FAULT_MASK_A) |=>
        rail_fault_mask_a_reg == $past(req_i.wdata))
        else $error("mask a write not stored");
    chk_mask_b_store: assert property (
        (req_i.write && req_i.addr == `ADDR_FAULT_MASK_B) |=>
        rail_fault_mask_b_reg == $past(req_i.wdata[1:0]))
        else $error("mask b write not stored");
    chk_rail4_mask: assert property (
        (rail_fault_mask_a_reg[7] && rail_fault_i.group_a[0]) |=>
        !rail_fault_active_o.group_a[0])
        else $error("rail 4 fault passed while masked");
    chk_rail13_mask: assert property (
        (!rail_fault_mask_a_reg[0] && rail_fault_i.group_a[7]) |=>
        rail_fault_active_o.group_a[7])
        else $error("rail 13 fault lost while unmasked");
    chk_rail11_mask: assert property (
        (rail_fault_mask_b_reg[1] && rail_fault_i.group_b[3]) |=>
        !rail_fault_active_o.group_b[3])
        else $error("rail 11 fault passed while masked");
    chk_rail12_mask: assert property (
        (rail_fault_mask_b_reg[0] && rail_fault_i.group_b[4]) |=>
        !rail_fault_active_o.group_b[4])
        else $error("rail 12 fault passed while masked");

    chk_config_write: assert property (s_write_config |=> ##1
        window_h_absolute_mode_o == ($past(req_i.wdata[2:0], 2) == `NOMINAL_CODE_1V0))
        else $error("config write not reaching decoder");
    chk_discharge_out: assert property (s_write_config |=>
        window_h_config_o.window_h_discharge_enable == $past(req_i.wdata[7]))
        else $error("discharge bit not stored");
    // only a write to its own address may move the config byte
    chk_config_hold: assert property (!wr_config |=>
        $stable(comparator_h_config_reg))
        else $error("config byte changed without a write");
    chk_misc_store: assert property (
        (req_i.write && req_i.addr == `ADDR_MISC_CONTROL) |=>
        miscellaneous_control_o == $past(req_i.wdata))
        else $error("misc write not stored");
endmodule

// *** test/host_port_model.sv ***
// host side of the register port: one byte write or read per call
// assumes the bank takes requests on the rising edge and answers one cycle later
`timescale 1ns/1ps
module host_port_model
    import rail_monitor_pkg::*;
(
    input wire logic clk_i,
    output rail_monitor_pkg::reg_req_s req_o,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i
);
    initial req_o = '0;
    // after release the address and data lines flip so a stale value never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        req_o = '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
        @(negedge clk_i);
        req_o = '{write: 1'b0, read: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk_i);
        req_o = '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk_i);
        d = rdata_i;
        v = rvalid_i;
        req_o = '{write: 1'b0, read: 1'b0, addr: ~a, wdata: 8'hFF};
    endtask
endmodule

// *** test/rail_monitor_fault_mask_regs_test.sv ***
// self-checking bench for the rail monitor register bank
// assumes the host model drives the register port on falling edges
`timescale 1ns/1ps
module rail_monitor_fault_mask_regs_test;
    import rail_monitor_pkg::*;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    reg_req_s req;
    logic [7:0] rdata, misc;
    logic rvalid, abs_mode, code_ok;
    logic [3:0] idx;
    rail_flags_s pass = '0, fault = '1, active;
    window_h_config_s cfg;
    int error_cnt = 0;
    int n_tests = 0;
    logic [7:0] d;
    logic v;
    logic [7:0] tcfg [4] = '{8'h48, 8'h50, 8'h41, 8'hB9};
    logic [5:0] texp [4] = '{6'h33, 6'h34, 6'h10, 6'h0F};
    always #2.5 clk_i = ~clk_i;
    host_port_model i_host_port_model (.clk_i(clk_i), .req_o(req), .rdata_i(rdata),
        .rvalid_i(rvalid));
    rail_monitor_fault_mask_regs i_rail_monitor_fault_mask_regs (.clk_i(clk_i),
        .reset_i(reset_i), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
        .rail_pass_i(pass), .rail_fault_i(fault), .window_h_config_o(cfg),
        .window_h_absolute_mode_o(abs_mode), .window_h_threshold_index_o(idx),
        .window_h_shift_code_valid_o(code_ok), .rail_fault_active_o(active),
        .miscellaneous_control_o(misc));
    task automatic cmp(input string what, input logic [12:0] exp, input logic [12:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        i_host_port_model.rd(a, d, v);
        cmp($sformatf("read %h", a), {5'h00, exp}, {5'h00, d});
        cmp("rvalid", 13'h0001, {12'h000, v});
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        #(5 * 3000);
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (6) @(negedge clk_i);
        reset_i = 1'b0;
        rdchk(8'hE4, 8'h00);
        rdchk(8'hE5, 8'h00);
        rdchk(8'hE6, 8'hFC);
        rdchk(8'hE7, 8'h00);
        rdchk(8'hE8, 8'hE0);
        rdchk(8'hE9, 8'h10);
        $display("test reset values done");
        i_host_port_model.wr(8'hE5, 8'hA5);
        rdchk(8'hE5, 8'hA5);
        i_host_port_model.wr(8'hE6, 8'h03);
        rdchk(8'hE6, 8'hFF);
        i_host_port_model.wr(8'hE9, 8'h5A);
        rdchk(8'hE9, 8'h5A);
        cmp("misc out", 13'h005A, {5'h00, misc});
        rdchk(8'hE0, 8'h00);
        $display("test read back done");
        pass = '{group_a: 8'hC3, group_b: 5'h1A};
        i_host_port_model.wr(8'hE7, 8'h3C);
        i_host_port_model.wr(8'hE8, 8'h05);
        rdchk(8'hE7, 8'hC3);
        rdchk(8'hE8, 8'hFA);
        pass = '{group_a: 8'h81, group_b: 5'h05};
        rdchk(8'hE7, 8'h81);
        rdchk(8'hE8, 8'hE5);
        $display("test status done");
        // first mask byte runs rail 4 to 13, status order runs 13 down to 4
        i_host_port_model.wr(8'hE5, 8'h01);
        i_host_port_model.wr(8'hE6, 8'h02);
        @(negedge clk_i);
        cmp("active faults", {8'h7F, 5'h17}, active);
        i_host_port_model.wr(8'hE5, 8'h80);
        i_host_port_model.wr(8'hE6, 8'h01);
        @(negedge clk_i);
        cmp("active faults", {8'hFE, 5'h0F}, active);
        // a fault pattern that is not all ones shows the gating is an and, not a copy
        fault = '{group_a: 8'h0F, group_b: 5'h15};
        @(negedge clk_i);
        cmp("active faults", {8'h0E, 5'h05}, active);
        $display("test fault masks done");
        for (int i = 0; i < 4; i++) begin
            i_host_port_model.wr(8'hE4, tcfg[i]);
            @(negedge clk_i);
            cmp("config out", {5'h00, tcfg[i]}, {5'h00, cfg});
            cmp("decode", {7'h00, texp[i]}, {7'h00, abs_mode, idx, code_ok});
            rdchk(8'hE4, tcfg[i]);
        end
        $display("test window decode done");
        reset_i = 1'b1;
        @(negedge clk_i);
        reset_i = 1'b0;
        rdchk(8'hE4, 8'h00);
        rdchk(8'hE6, 8'hFC);
        cmp("decode", 13'h0021, {7'h00, abs_mode, idx, code_ok});
        cmp("active faults", {8'h0F, 5'h15}, active);
        $display("test second reset done");
        summarize();
    end
endmodule
